/* dor_cell_group.sv */
// io cell group of four ddr-capable output cells behind an axi4-lite slave
// assumes core data on aclk, pins driven into an output buffer outside
//
// Notes on behaviour
// - core data is registered before it reaches the output buffer.
// - sdr mode: first data input feeds one storage element driving the pin.
// - that sdr element is configurable as edge register or level latch.
// - generic ddr: both data inputs captured at the output clock rising edge.
// - at the next falling edge the second captured bit moves to falling register.
// - generic ddr: output clock selects rising or falling register for the pin.
// - right edge supports sdr and generic ddr plus a ddr memory mode.
// - memory mode captures like generic ddr: rise capture, fall transfer.
// - memory mode output select runs on the shifted write strobe clock.
// - cells come in groups of four forming one io cell group.
// - two neighbouring cells can pair as complementary outputs, one inverted.
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module dor_cell_group #(
    parameter bit RIGHT_EDGE = 1'b1
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // axi4-lite write address
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [dor_pkg::AW-1:0]     s_axi_awaddr,
    // write data
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [dor_pkg::DW-1:0]     s_axi_wdata,
    input  wire logic [dor_pkg::DW/8-1:0]   s_axi_wstrb,
    // write response
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    // read address
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [dor_pkg::AW-1:0]     s_axi_araddr,
    // read data
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [dor_pkg::DW-1:0]          s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    // core side
    input  wire logic [dor_pkg::CELLS-1:0]  first_data_input,
    input  wire logic [dor_pkg::CELLS-1:0]  second_data_input,
    // towards the output buffers
    output logic [dor_pkg::CELLS-1:0]       pin_out,
    output logic                            core_out_clk,
    output logic                            shifted_write_strobe_clock
);

    // register bus state
    dor_pkg::dor_wr_e                 wr_state_r;
    dor_pkg::dor_rd_e                 rd_state_r;
    logic                             awready_r;
    logic                             wready_r;
    logic                             bvalid_r;
    logic [1:0]                       bresp_r;
    logic                             arready_r;
    logic                             rvalid_r;
    logic [dor_pkg::DW-1:0]           rdata_r;
    logic [1:0]                       rresp_r;
    logic                             aw_have_r;
    logic                             w_have_r;
    logic [dor_pkg::AW-1:0]           awaddr_r;
    logic [dor_pkg::DW-1:0]           wdata_r;
    logic [dor_pkg::DW/8-1:0]         wstrb_r;

    // block state
    logic [dor_pkg::CTRL_W-1:0]       ctrl_r;
    logic [dor_pkg::PH_W-1:0]         ph_r;
    logic [dor_pkg::CELLS-1:0]        pin_r;
    logic                             out_clk_r;
    logic                             strobe_r;
    dor_pkg::dor_phase_s              phase;
    dor_pkg::dor_cell_cfg_s           cell_cfg [dor_pkg::CELLS];
    logic [dor_pkg::CELLS-1:0]        cell_q;
    logic [dor_pkg::PAIRS-1:0]        pair_en;
    logic [dor_pkg::DW-1:0]           status_word;

    // word decode, shared by read and write paths
    function automatic logic [1:0] reg_hit(input logic [dor_pkg::AW-1:0] addr);
        logic [1:0] hit;
        hit = 2'h0;
        if (addr == dor_pkg::CTRL_OFF) begin
            hit = 2'h1;
        end else if (addr == dor_pkg::STAT_OFF) begin
            hit = 2'h2;
        end
        return hit;
    endfunction

    // memory mode exists only on the right edge; elsewhere it acts as generic
    function automatic logic [1:0] eff_mode(input logic [1:0] mode);
        logic [1:0] m;
        m = mode;
        if (!RIGHT_EDGE && mode == dor_pkg::MODE_DDR_MEM) begin
            m = dor_pkg::MODE_DDR_GEN;
        end
        return m;
    endfunction

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awaddr_r  <= '0;
            awready_r <= 1'b1;
        end else if (s_axi_awvalid && awready_r) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
            awready_r <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_have_r <= 1'b0;
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
            wready_r <= 1'b1;
        end else if (s_axi_wvalid && wready_r) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            wready_r <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_have_r <= 1'b0;
            wready_r <= 1'b1;
        end
    end

    // write response once both halves are held; one write in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= dor_pkg::WR_ACCEPT;
            bvalid_r   <= 1'b0;
            bresp_r    <= dor_pkg::RESP_OKAY;
        end else begin
            case (wr_state_r)
                dor_pkg::WR_ACCEPT: begin
                    if (aw_have_r && w_have_r) begin
                        wr_state_r <= dor_pkg::WR_RESP;
                        bvalid_r   <= 1'b1;
                        bresp_r    <= (reg_hit(awaddr_r) == 2'h1) ?
                                      dor_pkg::RESP_OKAY : dor_pkg::RESP_SLVERR;
                    end
                end
                dor_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r <= dor_pkg::WR_ACCEPT;
                        bvalid_r   <= 1'b0;
                    end
                end
                default: begin
                    wr_state_r <= dor_pkg::WR_ACCEPT;
                    bvalid_r   <= 1'b0;
                end
            endcase
        end
    end

    // control register, byte lanes honoured; status is read only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= dor_pkg::CTRL_RESET;
        end else if (wr_state_r == dor_pkg::WR_ACCEPT && aw_have_r && w_have_r
                     && reg_hit(awaddr_r) == 2'h1) begin
            if (wstrb_r[0]) begin
                ctrl_r[dor_pkg::LANE_W-1:0] <= wdata_r[dor_pkg::LANE_W-1:0];
            end
            if (wstrb_r[1]) begin
                ctrl_r[dor_pkg::CTRL_W-1:dor_pkg::LANE_W] <=
                    wdata_r[dor_pkg::CTRL_W-1:dor_pkg::LANE_W];
            end
        end
    end

    // status: pins, clock phase and whether memory mode is available
    always_comb begin
        status_word = '0;
        status_word[dor_pkg::CELLS-1:0] = pin_r;
        status_word[dor_pkg::STAT_PH_LSB +: dor_pkg::PH_W] = ph_r;
        status_word[dor_pkg::STAT_EDGE_BIT] = RIGHT_EDGE;
    end

    // read path: data one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= dor_pkg::RD_ACCEPT;
            arready_r  <= 1'b1;
            rvalid_r   <= 1'b0;
            rdata_r    <= '0;
            rresp_r    <= dor_pkg::RESP_OKAY;
        end else begin
            case (rd_state_r)
                dor_pkg::RD_ACCEPT: begin
                    if (s_axi_arvalid) begin
                        rd_state_r <= dor_pkg::RD_DATA;
                        arready_r  <= 1'b0;
                        rvalid_r   <= 1'b1;
                        case (reg_hit(s_axi_araddr))
                            2'h1: begin
                                rdata_r <= {{(dor_pkg::DW-dor_pkg::CTRL_W){1'b0}}, ctrl_r};
                                rresp_r <= dor_pkg::RESP_OKAY;
                            end
                            2'h2: begin
                                rdata_r <= status_word;
                                rresp_r <= dor_pkg::RESP_OKAY;
                            end
                            default: begin
                                rdata_r <= '0;
                                rresp_r <= dor_pkg::RESP_SLVERR;
                            end
                        endcase
                    end
                end
                dor_pkg::RD_DATA: begin
                    if (s_axi_rready) begin
                        rd_state_r <= dor_pkg::RD_ACCEPT;
                        arready_r  <= 1'b1;
                        rvalid_r   <= 1'b0;
                    end
                end
                default: begin
                    rd_state_r <= dor_pkg::RD_ACCEPT;
                    arready_r  <= 1'b1;
                    rvalid_r   <= 1'b0;
                end
            endcase
        end
    end

    // output clock phase: four aclk cycles, high in phases 0 and 1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ph_r <= '0;
        end else begin
            ph_r <= ph_r + 2'h1;
        end
    end

    // phase flags; edges are flagged in the cycle just before they occur
    always_comb begin
        phase.clk_high    = (ph_r <= dor_pkg::PH_LAST_HIGH);
        phase.strobe_high = (ph_r == dor_pkg::PH_STB_RISE) || (ph_r == dor_pkg::PH_STB_FALL);
        phase.rise_edge   = (ph_r == dor_pkg::PH_LAST_LOW);
        phase.fall_edge   = (ph_r == dor_pkg::PH_LAST_HIGH);
    end

    assign pair_en = ctrl_r[dor_pkg::CTRL_PAIR_LSB +: dor_pkg::PAIRS];

    // four cells form the group, each with its own mode field
    genvar gi;
    generate
        for (gi = 0; gi < dor_pkg::CELLS; gi++) begin : g_cell
            assign cell_cfg[gi].mode = eff_mode(ctrl_r[gi*dor_pkg::MODE_W +: dor_pkg::MODE_W]);
            dor_io_logic_cell u_cell (
                .aclk              (aclk),
                .aresetn           (aresetn),
                .cfg               (cell_cfg[gi]),
                .phase             (phase),
                .first_data_input  (first_data_input[gi]),
                .second_data_input (second_data_input[gi]),
                .q                 (cell_q[gi])
            );
        end
    endgenerate

    // pin flops; an odd cell of an enabled pair drives the inverse of its even mate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_r <= '0;
        end else begin
            for (int p = 0; p < dor_pkg::PAIRS; p++) begin
                pin_r[2*p] <= cell_q[2*p];
                if (pair_en[p]) begin
                    pin_r[2*p+1] <= ~cell_q[2*p];
                end else begin
                    pin_r[2*p+1] <= cell_q[2*p+1];
                end
            end
        end
    end

    // clocks leave through flops too, so they stay aligned with the pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_clk_r <= 1'b0;
            strobe_r  <= 1'b0;
        end else begin
            out_clk_r <= phase.clk_high;
            strobe_r  <= phase.strobe_high;
        end
    end

    assign pin_out                    = pin_r;
    assign core_out_clk               = out_clk_r;
    assign shifted_write_strobe_clock = strobe_r;

endmodule

`default_nettype wire

/* dor_cell_group_asserts.sv */
// port assertions and covers for the ddr output register group
// assumes it is bound into dor_cell_group and everything runs on aclk
`timescale 1ns/1ps
`default_nettype none

module dor_cell_group_chk (
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire logic                      s_axi_awvalid,
    input wire logic                      s_axi_awready,
    input wire logic                      s_axi_wvalid,
    input wire logic                      s_axi_wready,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic [1:0]                s_axi_bresp,
    input wire logic                      s_axi_arvalid,
    input wire logic                      s_axi_arready,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    input wire logic [dor_pkg::DW-1:0]    s_axi_rdata,
    input wire logic [dor_pkg::CELLS-1:0] pin_out,
    input wire logic                      core_out_clk,
    input wire logic                      shifted_write_strobe_clock
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // outputs must come out of reset quiet, before any core data lands
    a_reset_quiet: assert property ($rose(aresetn) |->
        !s_axi_bvalid && !s_axi_rvalid && pin_out == 4'h0 && !core_out_clk && s_axi_awready)
        else $error("outputs not idle after reset");
    // output clock is two high, two low: the mux select of generic ddr
    a_clk_shape: assert property ($rose(core_out_clk) |->
        core_out_clk [*2] ##1 !core_out_clk [*2] ##1 core_out_clk)
        else $error("output clock shape wrong");
    // strobe is the output clock one quarter period later
    a_strobe_lag: assert property (shifted_write_strobe_clock == $past(core_out_clk))
        else $error("strobe not one cycle behind output clock");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read data late");
    a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");

    c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == dor_pkg::RESP_SLVERR);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_pin_strobe: cover property ($rose(shifted_write_strobe_clock) && pin_out != 4'h0);
endmodule

bind dor_cell_group dor_cell_group_chk dor_cell_group_chk_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pin_out, .core_out_clk,
    .shifted_write_strobe_clock
);

`default_nettype wire

/* dor_io_logic_cell.sv */
// one io logic cell: sdr register or latch, generic ddr and ddr memory capture
// assumes phase flags from the group, all on aclk; q is combinational
`timescale 1ns/1ps
`default_nettype none

module dor_io_logic_cell (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire dor_pkg::dor_cell_cfg_s cfg,
    input  wire dor_pkg::dor_phase_s    phase,
    input  wire logic               first_data_input,
    input  wire logic               second_data_input,
    output logic                    q
);

    logic sdr_reg_r;
    logic sdr_latch_r;
    logic rising_capture_reg_r;
    logic second_hold_r;
    logic falling_capture_reg_r;

    // sdr storage element, register flavour: rising edge of output clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdr_reg_r <= 1'b0;
        end else if (phase.rise_edge) begin
            sdr_reg_r <= first_data_input;
        end
    end

    // latch flavour: follows the input while the output clock is high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdr_latch_r <= 1'b0;
        end else if (phase.clk_high) begin
            sdr_latch_r <= first_data_input;
        end
    end

    // both inputs taken at the rising edge, same in both ddr modes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rising_capture_reg_r <= 1'b0;
            second_hold_r        <= 1'b0;
        end else if (phase.rise_edge) begin
            rising_capture_reg_r <= first_data_input;
            second_hold_r        <= second_data_input;
        end
    end

    // second bit moves over at the following falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            falling_capture_reg_r <= 1'b0;
        end else if (phase.fall_edge) begin
            falling_capture_reg_r <= second_hold_r;
        end
    end

    // output select; mem mode switches on the shifted strobe instead
    always_comb begin
        case (cfg.mode)
            dor_pkg::MODE_SDR_REG: begin
                q = sdr_reg_r;
            end
            dor_pkg::MODE_SDR_LATCH: begin
                q = sdr_latch_r;
            end
            dor_pkg::MODE_DDR_GEN: begin
                q = phase.clk_high ? rising_capture_reg_r : falling_capture_reg_r;
            end
            dor_pkg::MODE_DDR_MEM: begin
                q = phase.strobe_high ? rising_capture_reg_r : falling_capture_reg_r;
            end
            default: begin
                q = sdr_reg_r;
            end
        endcase
    end

endmodule

`default_nettype wire

/* dor_pad_model.sv */
// output buffers and pads fed by the cell group
// assumes active-high pins and an always-enabled buffer, no pull needed
`timescale 1ns/1ps
`default_nettype none

module dor_pad_model (
    input  wire logic [3:0] pin,
    output var  logic [3:0] pad
);
    // buffer is transparent; drive strength is not modelled
    always_comb pad = pin;
endmodule

`default_nettype wire

/* dor_pkg.sv */
// shared constants, field layout and carrier types of the ddr output register group
// assumes one 100 MHz system clock and an axi4-lite register port
`default_nettype none

package dor_pkg;

    // four io logic cells make one io cell group
    localparam int CELLS = 4;
    localparam int PAIRS = 2;

    // register bus
    localparam int AW = 8;
    localparam int DW = 32;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // cell modes
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_SDR_REG   = 2'h0;
    localparam logic [1:0] MODE_SDR_LATCH = 2'h1;
    localparam logic [1:0] MODE_DDR_GEN   = 2'h2;
    localparam logic [1:0] MODE_DDR_MEM   = 2'h3;

    // control and status field layout
    localparam int CTRL_W        = 10;
    localparam int CTRL_PAIR_LSB = 8;
    localparam int LANE_W        = 8;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam int STAT_PH_LSB   = 4;
    localparam int STAT_EDGE_BIT = 6;

    // output clock built from aclk: four aclk cycles per period
    localparam int ACLK_PERIOD_NS    = 10;
    localparam int OUTCLK_PERIOD_NS  = 40;
    localparam int PH_W              = 2;
    localparam int PH_COUNT          = OUTCLK_PERIOD_NS / ACLK_PERIOD_NS;
    localparam logic [1:0] PH_LAST_HIGH = 2'h1;   // falling edge follows
    localparam logic [1:0] PH_LAST_LOW  = 2'h3;   // rising edge follows
    localparam logic [1:0] PH_STB_RISE  = 2'h1;   // strobe lags by a quarter
    localparam logic [1:0] PH_STB_FALL  = 2'h2;

    typedef enum logic [1:0] {
        WR_ACCEPT = 2'b01,
        WR_RESP   = 2'b10
    } dor_wr_e;

    typedef enum logic [1:0] {
        RD_ACCEPT = 2'b01,
        RD_DATA   = 2'b10
    } dor_rd_e;

    typedef struct packed {
        logic [1:0] mode;
    } dor_cell_cfg_s;

    typedef struct packed {
        logic clk_high;
        logic strobe_high;
        logic rise_edge;
        logic fall_edge;
    } dor_phase_s;

endpackage

`default_nettype wire

/* tb_top.sv */
// self-checking bench for the ddr output register group
// assumes dor_pkg compiled first, checker bound in, pads behind the pins
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        aclk, aresetn, drive, e_clk, e_stb, oclk, stb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, da, db, pin, pad, r0, r1, f, lat, e_pin;
    logic [1:0]  bresp, rresp;
    logic [9:0]  cur_ctrl;
    int          num_errors, checked, settle, ph, c;

    dor_cell_group dor_cell_group_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .first_data_input(da), .second_data_input(db), .pin_out(pin),
        .core_out_clk(oclk), .shifted_write_strobe_clock(stb));
    dor_pad_model dor_pad_model_i (.pin(pin), .pad(pad));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic end_sim;
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp_reg(input string name, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cmp_pin(input string name, input logic [3:0] e, input logic [3:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    // every bus wait is bounded; a hang ends the run as a failure
    task automatic guard(inout int n);
        n++;
        if (n > 200) begin
            num_errors++;
            end_sim();
        end
    endtask

    // expected control register after a write with byte strobes
    function automatic logic [9:0] merge(logic [9:0] o, logic [31:0] d, logic [3:0] s);
        merge = o;
        if (s[0]) merge[7:0] = d[7:0];
        if (s[1]) merge[9:8] = d[9:8];
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int n;
        n = 0;
        settle = 16;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        if (a == dor_pkg::CTRL_OFF) cur_ctrl = merge(cur_ctrl, d, s);
        settle = 16;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
        end while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            guard(n);
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // random core data every cycle, the worst case for capture timing
    always @(posedge aclk) begin
        if (drive) begin
            da <= 4'($urandom());
            db <= 4'($urandom());
        end
    end

    // reference: outputs after each edge come from state before it
    always @(posedge aclk) begin
        if (settle > 0) settle--;
        if (!aresetn) begin
            ph = 0;
            {r0, r1, f, lat, e_pin, e_clk, e_stb} = '0;
            cur_ctrl = '0;
        end else begin
            for (c = 0; c < 4; c++) begin
                case (cur_ctrl[2*c +: 2])
                    dor_pkg::MODE_SDR_REG:   e_pin[c] = r0[c];
                    dor_pkg::MODE_SDR_LATCH: e_pin[c] = lat[c];
                    dor_pkg::MODE_DDR_GEN:   e_pin[c] = (ph < 2) ? r0[c] : f[c];
                    default:                 e_pin[c] = (ph == 1 || ph == 2) ? r0[c] : f[c];
                endcase
            end
            if (cur_ctrl[8]) e_pin[1] = ~e_pin[0];
            if (cur_ctrl[9]) e_pin[3] = ~e_pin[2];
            e_clk = (ph < 2);
            e_stb = (ph == 1 || ph == 2);
            if (ph == 1) f = r1;
            if (ph == 3) r0 = da;
            if (ph == 3) r1 = db;
            if (ph < 2) lat = da;
            ph = (ph + 1) % 4;
        end
    end

    // compare mid-cycle, away from the edge; skipped while a mode switch settles
    always @(negedge aclk) begin
        if (aresetn && settle == 0) begin
            cmp_pin("pin_out", e_pin, pin);
            cmp_pin("pad", e_pin, pad);
            cmp_pin("clocks", {2'b00, e_clk, e_stb}, {2'b00, oclk, stb});
        end
    end

    initial begin
        logic [31:0] v, g;
        logic [1:0]  r;
        int          i;
        {aresetn, drive, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, da, db} = '0;
        {num_errors, checked, settle} = '0;
        void'($urandom(32'h0365));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        drive <= 1'b1;
        @(posedge aclk);
        axi_rd(dor_pkg::CTRL_OFF, g, r);
        cmp_reg("ctrl reset", 32'h0, g);
        axi_rd(dor_pkg::STAT_OFF, g, r);
        cmp_reg("status edge", 32'h40, g & 32'hffffffc0);
        // every mode on all cells, then random mixes with pairing
        for (i = 0; i < 10; i++) begin
            v = $urandom();
            if (i < 4) v[7:0] = {4{2'(i)}};
            axi_wr(dor_pkg::CTRL_OFF, v, 4'hf, r);
            cmp_reg("ctrl wr resp", {30'h0, dor_pkg::RESP_OKAY}, {30'h0, r});
            axi_rd(dor_pkg::CTRL_OFF, g, r);
            cmp_reg("ctrl", {22'h0, v[9:0]}, g);
            repeat (40) @(posedge aclk);
        end
        // byte strobes, then refused writes and an unmapped read
        axi_wr(dor_pkg::CTRL_OFF, 32'h300, 4'hf, r);
        axi_wr(dor_pkg::CTRL_OFF, 32'h0ff, 4'h1, r);
        axi_rd(dor_pkg::CTRL_OFF, g, r);
        cmp_reg("ctrl lane0", 32'h3ff, g);
        axi_wr(dor_pkg::CTRL_OFF, 32'h0, 4'h2, r);
        axi_wr(dor_pkg::STAT_OFF, 32'h0, 4'hf, r);
        cmp_reg("status wr resp", {30'h0, dor_pkg::RESP_SLVERR}, {30'h0, r});
        axi_wr(8'h0c, 32'h0, 4'hf, r);
        cmp_reg("unmapped wr resp", {30'h0, dor_pkg::RESP_SLVERR}, {30'h0, r});
        axi_rd(8'h0c, g, r);
        cmp_reg("unmapped rd", {dor_pkg::RESP_SLVERR, 30'h0}, {r, g[29:0]});
        axi_rd(dor_pkg::CTRL_OFF, g, r);
        cmp_reg("ctrl kept", 32'h0ff, g);
        repeat (40) @(posedge aclk);
        // reset in mid-run with data still moving
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(dor_pkg::CTRL_OFF, g, r);
        cmp_reg("ctrl after reset", 32'h0, g);
        repeat (20) @(posedge aclk);
        end_sim();
    end
endmodule

`default_nettype wire
